// [swi_pkg.sv]
// package: register map, field positions, states and constants of the sleep/wake and interrupt block
package swi_pkg;
    // ----------------------------------------
    // register byte addresses (index times four)
    // ----------------------------------------
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h0E;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0F;
    localparam logic [7:0] IDX_CTRL = 8'h04;
    localparam logic [7:0] IDX_STATE = 8'h20;
    localparam logic [9:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'b00};
    localparam logic [9:0] ADDR_IRQ_FLAGS = {IDX_IRQ_FLAGS, 2'b00};
    localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] ADDR_STATE = {IDX_STATE, 2'b00};
    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int CTRL_POLARITY_BIT = 0;
    localparam int CTRL_POLL_BIT = 1;
    localparam int CTRL_CLKSEL_LSB = 4;
    localparam int CTRL_CMD_LSB = 8;
    localparam logic [7:0] CTRL_RESET = 8'h02;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    // ----------------------------------------
    // flag bit positions
    // ----------------------------------------
    localparam int FLAG_LOCK = 0;
    localparam int FLAG_UNLOCK = 1;
    localparam int FLAG_RX_START = 2;
    localparam int FLAG_FRAME_END = 3;
    localparam int FLAG_WAKE_DONE = 4;
    localparam int FLAG_ADDR_MATCH = 5;
    localparam int FLAG_BUF_VIOL = 6;
    localparam int FLAG_SUPPLY_LOW = 7;
    // ----------------------------------------
    // clock output rate selection
    // ----------------------------------------
    localparam logic [2:0] CLKSEL_OFF = 3'h0;
    localparam logic [2:0] CLKSEL_1MHZ = 3'h1;
    localparam logic [2:0] CLKSEL_2MHZ = 3'h2;
    localparam logic [2:0] CLKSEL_250KHZ = 3'h3;
    localparam logic [2:0] CLKSEL_62K5HZ = 3'h4;
    localparam logic [7:0] HALF_1MHZ = 8'h0A;
    localparam logic [7:0] HALF_2MHZ = 8'h05;
    localparam logic [7:0] HALF_250KHZ = 8'h28;
    localparam logic [7:0] HALF_62K5HZ = 8'hA0;
    localparam logic [5:0] TRAIL_CYCLES = 6'h23;
    // ----------------------------------------
    // state commands written by software
    // ----------------------------------------
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_RADIO_OFF = 3'h1;
    localparam logic [2:0] CMD_SYNTH_ON = 3'h2;
    localparam logic [2:0] CMD_TX_RETRY = 3'h3;
    localparam logic [2:0] CMD_RX_ACK = 3'h4;
    localparam logic [2:0] CMD_PREP_DEEP = 3'h5;
    typedef enum logic [3:0] {
        ST_RADIO_OFF,
        ST_SYNTH_ON,
        ST_TX_RETRY,
        ST_RX_ACK,
        ST_BUSY_RX_ACK,
        ST_BUSY_TX,
        ST_BUSY_TX_RETRY,
        ST_PREP_DEEP,
        ST_SLEEP,
        ST_DEEP_SLEEP,
        ST_WAKING
    } swi_state_t;
endpackage : swi_pkg

// [swi_sleep_wake_irq.sv]
// module: sleep/transmit pin control, host clock gating and interrupt unit with AHB-Lite slave
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
module swi_sleep_wake_irq (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sleepTransmitPin,
    input wire logic synthLockEvent,
    input wire logic synthUnlockEvent,
    input wire logic rxStartEvent,
    input wire logic frameEndEvent,
    input wire logic channelAssessDoneEvent,
    input wire logic addressMatchEvent,
    input wire logic bufferViolationEvent,
    input wire logic supplyLowEvent,
    input wire logic txDoneEvent,
    input wire logic wakeDoneEvent,
    output logic irqPin,
    output logic hostClockOutput,
    output logic txStart,
    output logic ackTxStart,
    output logic paEnable,
    output swi_pkg::swi_state_t radioState
);
    import swi_pkg::*;

    // ----------------------------------------
    // state record
    // ----------------------------------------
    typedef struct packed {
        logic pinMeta;
        logic pinSync;
        logic pinPrev;
        swi_state_t state;
        logic [7:0] enable;
        logic [7:0] flags;
        logic polarity;
        logic poll;
        logic [2:0] clkSel;
        logic [7:0] clkDiv;
        logic clkOut;
        logic clkRun;
        logic [5:0] trail;
        logic trailing;
        logic dataPhase;
        logic dataWrite;
        logic [9:0] dataAddr;
        logic [31:0] rdata;
        logic irq;
        logic txStart;
        logic ackStart;
        logic pa;
        logic pinEntered;
    } swi_regs_t;

    swi_regs_t cur_r;
    swi_regs_t cur_nxt;

    logic pinRise;
    logic pinFall;
    logic [7:0] events;
    logic [7:0] shown;
    logic [7:0] half;
    logic addrPhase;
    logic readFlags;
    logic enterSleep;

    always_comb begin
        // ----------------------------------------
        // pin edges and event vector
        // ----------------------------------------
        pinRise = cur_r.pinSync & ~cur_r.pinPrev;
        pinFall = ~cur_r.pinSync & cur_r.pinPrev;
        events = '0;
        events[FLAG_LOCK] = synthLockEvent;
        events[FLAG_UNLOCK] = synthUnlockEvent;
        events[FLAG_RX_START] = rxStartEvent
            | (cur_r.state == ST_RX_ACK && rxStartEvent);
        events[FLAG_FRAME_END] = frameEndEvent | txDoneEvent;
        events[FLAG_WAKE_DONE] = wakeDoneEvent | channelAssessDoneEvent;
        events[FLAG_ADDR_MATCH] = addressMatchEvent;
        events[FLAG_BUF_VIOL] = bufferViolationEvent;
        events[FLAG_SUPPLY_LOW] = supplyLowEvent;
        shown = cur_r.poll ? events : (events & cur_r.enable);
        case (cur_r.clkSel)
            CLKSEL_2MHZ: half = HALF_2MHZ;
            CLKSEL_250KHZ: half = HALF_250KHZ;
            CLKSEL_62K5HZ: half = HALF_62K5HZ;
            default: half = HALF_1MHZ;
        endcase
        addrPhase = hsel & hready & htrans[1];
        readFlags = cur_r.dataPhase & ~cur_r.dataWrite & (cur_r.dataAddr == ADDR_IRQ_FLAGS);

        cur_nxt = cur_r;
        cur_nxt.pinMeta = sleepTransmitPin;
        cur_nxt.pinSync = cur_r.pinMeta;
        cur_nxt.pinPrev = cur_r.pinSync;
        cur_nxt.txStart = 1'b0;
        cur_nxt.ackStart = 1'b0;
        enterSleep = 1'b0;

        // ----------------------------------------
        // bus slave
        // ----------------------------------------
        cur_nxt.dataPhase = addrPhase;
        if (addrPhase) begin
            cur_nxt.dataWrite = hwrite;
            cur_nxt.dataAddr = haddr[9:0];
        end
        if (cur_r.dataPhase && cur_r.dataWrite) begin
            case (cur_r.dataAddr)
                ADDR_IRQ_ENABLE: cur_nxt.enable = hwdata[7:0];
                ADDR_CTRL: begin
                    cur_nxt.polarity = hwdata[CTRL_POLARITY_BIT];
                    cur_nxt.poll = hwdata[CTRL_POLL_BIT];
                    cur_nxt.clkSel = hwdata[CTRL_CLKSEL_LSB +: 3];
                    case (hwdata[CTRL_CMD_LSB +: 3])
                        CMD_RADIO_OFF: cur_nxt.state = ST_RADIO_OFF;
                        CMD_SYNTH_ON: cur_nxt.state = ST_SYNTH_ON;
                        CMD_TX_RETRY: cur_nxt.state = ST_TX_RETRY;
                        CMD_RX_ACK: cur_nxt.state = ST_RX_ACK;
                        CMD_PREP_DEEP: cur_nxt.state = ST_PREP_DEEP;
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
        if (addrPhase && !hwrite) begin
            case (haddr[9:0])
                ADDR_IRQ_ENABLE: cur_nxt.rdata = {24'h000000, cur_r.enable};
                ADDR_IRQ_FLAGS: cur_nxt.rdata = {24'h000000, cur_r.flags};
                ADDR_CTRL: cur_nxt.rdata = {24'h000000, 1'b0, cur_r.clkSel, 2'b00,
                    cur_r.poll, cur_r.polarity};
                ADDR_STATE: cur_nxt.rdata = {28'h0000000, cur_r.state};
                default: cur_nxt.rdata = 32'h00000000;
            endcase
        end

        // ----------------------------------------
        // flags: read clears, new events win
        // ----------------------------------------
        if (readFlags) begin
            cur_nxt.flags = 8'h00;
        end
        cur_nxt.flags = cur_nxt.flags | shown;
        if (shown[FLAG_LOCK]) begin
            cur_nxt.flags[FLAG_UNLOCK] = shown[FLAG_UNLOCK];
        end
        if (shown[FLAG_UNLOCK]) begin
            cur_nxt.flags[FLAG_LOCK] = shown[FLAG_LOCK];
        end
        cur_nxt.irq = (|(cur_nxt.flags & cur_nxt.enable)) ^ cur_nxt.polarity;

        // ----------------------------------------
        // radio state and pin functions
        // ----------------------------------------
        case (cur_r.state)
            ST_SYNTH_ON: if (pinRise) begin
                cur_nxt.txStart = 1'b1;
                cur_nxt.state = ST_BUSY_TX;
                cur_nxt.pa = 1'b1;
            end
            ST_TX_RETRY: if (pinRise) begin
                cur_nxt.txStart = 1'b1;
                cur_nxt.state = ST_BUSY_TX_RETRY;
                cur_nxt.pa = 1'b1;
            end
            ST_RX_ACK: if (rxStartEvent) begin
                cur_nxt.state = ST_BUSY_RX_ACK;
            end
            ST_BUSY_RX_ACK: begin
                if (pinRise) begin
                    cur_nxt.ackStart = 1'b1;
                end
                if (frameEndEvent) begin
                    cur_nxt.state = ST_RX_ACK;
                end
            end
            ST_BUSY_TX, ST_BUSY_TX_RETRY: begin
                if (synthUnlockEvent || txDoneEvent) begin
                    cur_nxt.pa = 1'b0;
                    cur_nxt.state = (cur_r.state == ST_BUSY_TX) ? ST_SYNTH_ON : ST_TX_RETRY;
                end
            end
            ST_RADIO_OFF: if (pinRise) begin
                cur_nxt.state = ST_SLEEP;
                enterSleep = 1'b1;
            end
            ST_PREP_DEEP: if (pinRise) begin
                cur_nxt.state = ST_DEEP_SLEEP;
                enterSleep = 1'b1;
            end
            ST_SLEEP: if (pinFall || !cur_r.pinSync) begin
                cur_nxt.state = ST_WAKING;
            end
            ST_DEEP_SLEEP: if (pinFall || !cur_r.pinSync) begin
                cur_nxt = '0;
                cur_nxt.poll = CTRL_RESET[CTRL_POLL_BIT];
                cur_nxt.clkSel = CLKSEL_1MHZ;
                cur_nxt.clkRun = 1'b1;
                cur_nxt.state = ST_WAKING;
                cur_nxt.pinSync = cur_r.pinMeta;
                cur_nxt.pinPrev = cur_r.pinSync;
                cur_nxt.pinMeta = sleepTransmitPin;
            end
            ST_WAKING: begin
                cur_nxt.state = ST_RADIO_OFF;
                cur_nxt.clkRun = 1'b1;
                cur_nxt.trailing = 1'b0;
                cur_nxt.flags = cur_nxt.flags | (cur_r.poll | cur_r.enable[FLAG_WAKE_DONE]
                    ? (8'h01 << FLAG_WAKE_DONE) : 8'h00);
            end
            default: cur_nxt.state = ST_RADIO_OFF;
        endcase

        // ----------------------------------------
        // host clock output with trailing cycles at 1 MHz and 2 MHz, stopped at once at 250 kHz and 62.5 kHz
        // ----------------------------------------
        if (enterSleep) begin
            cur_nxt.trailing = 1'b1;
            cur_nxt.trail = TRAIL_CYCLES;
        end
        if (cur_r.clkRun && cur_r.clkSel != CLKSEL_OFF) begin
            if (cur_r.clkDiv + 8'h01 >= half) begin
                cur_nxt.clkDiv = 8'h00;
                cur_nxt.clkOut = ~cur_r.clkOut;
                // count rising edges from entry on, stop at the fall after the last
                if (cur_nxt.trailing && !cur_r.clkOut) begin
                    cur_nxt.trail = cur_nxt.trail - 6'h01;
                end else if (cur_nxt.trailing && cur_nxt.trail == 6'h00) begin
                    cur_nxt.clkRun = 1'b0;
                    cur_nxt.trailing = 1'b0;
                end
            end else begin
                cur_nxt.clkDiv = cur_r.clkDiv + 8'h01;
            end
        end else begin
            cur_nxt.clkOut = 1'b0;
            cur_nxt.clkDiv = 8'h00;
        end
        if (enterSleep && (cur_r.clkSel == CLKSEL_250KHZ || cur_r.clkSel == CLKSEL_62K5HZ)) begin
            cur_nxt.clkRun = 1'b0;
            cur_nxt.trailing = 1'b0;
            cur_nxt.clkOut = 1'b0;
            cur_nxt.clkDiv = 8'h00;
        end
    end

    // ----------------------------------------
    // register stage
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            cur_r <= '0;
            cur_r.poll <= CTRL_RESET[CTRL_POLL_BIT];
            cur_r.clkSel <= CLKSEL_1MHZ;
            cur_r.clkRun <= 1'b1;
            cur_r.state <= ST_WAKING;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign hrdata = cur_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irqPin = cur_r.irq;
    assign hostClockOutput = cur_r.clkOut;
    assign txStart = cur_r.txStart;
    assign ackTxStart = cur_r.ackStart;
    assign paEnable = cur_r.pa;
    assign radioState = cur_r.state;
endmodule : swi_sleep_wake_irq

// [swi_sleep_wake_irq_asserts.sv]
// checker: timing properties at the ports of the sleep/wake and interrupt block
`timescale 1ns/100ps
module swi_sleep_wake_irq_asserts (
    input logic clock,
    input logic rst,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    input logic [31:0] hrdata,
    input logic hreadyout,
    input logic hresp,
    input logic sleepTransmitPin,
    input logic synthLockEvent,
    input logic synthUnlockEvent,
    input logic rxStartEvent,
    input logic frameEndEvent,
    input logic channelAssessDoneEvent,
    input logic addressMatchEvent,
    input logic bufferViolationEvent,
    input logic supplyLowEvent,
    input logic txDoneEvent,
    input logic wakeDoneEvent,
    input logic irqPin,
    input logic hostClockOutput,
    input logic txStart,
    input logic ackTxStart,
    input logic paEnable,
    input swi_pkg::swi_state_t radioState
);
    import swi_pkg::*;
    logic [7:0] enTrk;
    logic polTrk;
    logic wrEn;
    logic [9:0] wrAddr;
    logic [9:0] sleepCnt;
    logic [7:0] evVec;
    logic anyEv;
    logic asleep;
    logic wasDeep;
    assign evVec = {supplyLowEvent, bufferViolationEvent, addressMatchEvent,
        channelAssessDoneEvent | wakeDoneEvent, frameEndEvent | txDoneEvent, rxStartEvent,
        synthUnlockEvent, synthLockEvent};
    assign anyEv = (|evVec) || (radioState == ST_WAKING);
    assign asleep = (radioState == ST_SLEEP) || (radioState == ST_DEEP_SLEEP);
    // shadow of enable and polarity, cleared like the real registers
    always_ff @(posedge clock) begin
        wrEn <= hsel && hready && htrans[1] && hwrite;
        wrAddr <= haddr[9:0];
        sleepCnt <= asleep ? sleepCnt + {9'h000, sleepCnt != 10'h3FF} : 10'h000;
        wasDeep <= radioState == ST_DEEP_SLEEP;
        if (rst || (wasDeep && radioState == ST_WAKING)) begin
            enTrk <= 8'h00;
            polTrk <= 1'b0;
        end else if (wrEn && wrAddr == ADDR_IRQ_ENABLE) begin
            enTrk <= hwdata[7:0];
        end else if (wrEn && wrAddr == ADDR_CTRL) begin
            polTrk <= hwdata[CTRL_POLARITY_BIT];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    tx_single_a: assert property (txStart |=> !txStart)
        else $error("transmit start longer than one cycle");
    ack_single_a: assert property (ackTxStart |=> !ackTxStart)
        else $error("ack start longer than one cycle");
    sleep_hold_a: assert property (sleepTransmitPin [*4] ##0 asleep |=> $stable(radioState))
        else $error("left sleep while pin high");
    clk_stop_a: assert property (sleepCnt > 10'h320 |-> $stable(hostClockOutput))
        else $error("clock output still running in sleep");
    mask_quiet_a: assert property ((enTrk == 8'h00 && $past(enTrk) == 8'h00 && $stable(polTrk))
        |-> irqPin == polTrk)
        else $error("request active with all sources masked");
    irq_raise_a: assert property ((|(evVec & enTrk)) && $stable(polTrk)
        |-> ##[1:3] irqPin != polTrk)
        else $error("enabled event gave no request");
    read_clear_a: assert property ((hsel && hready && htrans[1] && !hwrite
        && haddr[9:0] == ADDR_IRQ_FLAGS) ##1 !anyEv [*3] |-> irqPin == polTrk)
        else $error("request still active after flag read");
    pa_cut_a: assert property (synthUnlockEvent && (radioState == ST_BUSY_TX
        || radioState == ST_BUSY_TX_RETRY) |-> ##[1:2] !paEnable)
        else $error("amplifier on after unlock");
endmodule : swi_sleep_wake_irq_asserts

bind swi_sleep_wake_irq swi_sleep_wake_irq_asserts chk (.clock(clock), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sleepTransmitPin(sleepTransmitPin), .synthLockEvent(synthLockEvent),
    .synthUnlockEvent(synthUnlockEvent), .rxStartEvent(rxStartEvent),
    .frameEndEvent(frameEndEvent), .channelAssessDoneEvent(channelAssessDoneEvent),
    .addressMatchEvent(addressMatchEvent), .bufferViolationEvent(bufferViolationEvent),
    .supplyLowEvent(supplyLowEvent), .txDoneEvent(txDoneEvent), .wakeDoneEvent(wakeDoneEvent),
    .irqPin(irqPin), .hostClockOutput(hostClockOutput), .txStart(txStart),
    .ackTxStart(ackTxStart), .paEnable(paEnable), .radioState(radioState));

// [swi_host_model.sv]
// model: host side driving the sleep/transmit pin and counting clock output pulses
`timescale 1ns/100ps
module swi_host_model (
    input logic clock,
    input logic pinReq,
    input logic countClear,
    input logic countEn,
    input logic hostClockOutput,
    output logic sleepTransmitPin,
    output logic [9:0] clkEdges
);
    logic clkPrev = 1'b0;
    initial begin
        sleepTransmitPin = 1'b0;
        clkEdges = 10'h000;
    end
    always @(posedge clock) begin
        sleepTransmitPin <= pinReq;
        clkPrev <= hostClockOutput;
        if (countClear) begin
            clkEdges <= 10'h000;
        end else if (countEn && hostClockOutput && !clkPrev) begin
            clkEdges <= clkEdges + 10'h001;
        end
    end
endmodule : swi_host_model

// [test_sleep_wake_and_interrupt_logic.sv]
// testbench: register, event and pin sequences for the sleep/wake and interrupt block
`timescale 1ns/100ps
module test_sleep_wake_and_interrupt_logic;
    import swi_pkg::*;
    logic clock, rst, hsel, hwrite, hready, hreadyout, hresp, pinReq, countClear;
    logic irqPin, hostClockOutput, txStart, ackTxStart, paEnable, sleepTransmitPin;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [9:0] ev, clkEdges;
    swi_state_t radioState;
    int failCount = 0;
    int checksDone = 0;
    int cyc = 0;
    int txSeen = 0;
    int ackSeen = 0;
    assign hready = hreadyout;
    swi_sleep_wake_irq dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sleepTransmitPin(sleepTransmitPin), .synthLockEvent(ev[0]), .synthUnlockEvent(ev[1]),
        .rxStartEvent(ev[2]), .frameEndEvent(ev[3]), .channelAssessDoneEvent(ev[4]),
        .addressMatchEvent(ev[5]), .bufferViolationEvent(ev[6]), .supplyLowEvent(ev[7]),
        .wakeDoneEvent(ev[8]), .txDoneEvent(ev[9]), .irqPin(irqPin),
        .hostClockOutput(hostClockOutput), .txStart(txStart), .ackTxStart(ackTxStart),
        .paEnable(paEnable), .radioState(radioState));
    swi_host_model host (.clock(clock), .pinReq(pinReq), .countClear(countClear),
        .countEn(radioState == ST_SLEEP || radioState == ST_DEEP_SLEEP),
        .hostClockOutput(hostClockOutput), .sleepTransmitPin(sleepTransmitPin),
        .clkEdges(clkEdges));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tallyAndFinish
    always @(posedge clock) begin
        cyc++;
        if (txStart === 1'b1) txSeen++;
        if (ackTxStart === 1'b1) ackSeen++;
        if (cyc == 20000) begin
            failCount++;
            tallyAndFinish();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic ahb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h000000, a};
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic rdChk(input string what, input logic [9:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h00000000);
        chk(what, exp, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : rdChk
    task automatic pulse(input int i);
        @(posedge clock);
        ev[i] <= 1'b1;
        @(posedge clock);
        ev <= 10'h000;
    endtask : pulse
    task automatic waitSt(input swi_state_t s);
        int n;
        n = 0;
        while (radioState !== s && n < 60) begin
            @(posedge clock);
            n++;
        end
        chk("radioState", {28'h0000000, s}, {28'h0000000, radioState});
    endtask : waitSt
    task automatic irqChk(input logic exp);
        repeat (3) @(posedge clock);
        chk("irqPin", {31'h00000000, exp}, {31'h00000000, irqPin});
    endtask : irqChk
    task automatic sleepRun(input logic [31:0] ctrl, input swi_state_t s, input logic [9:0] n);
        ahb(1'b1, ADDR_CTRL, ctrl);
        countClear <= 1'b1;
        pinReq <= 1'b1;
        @(posedge clock);
        countClear <= 1'b0;
        waitSt(s);
        repeat (1000) @(posedge clock);
        chk("clock pulses", {22'h000000, n}, {22'h000000, clkEdges});
        pinReq <= 1'b0;
        waitSt(ST_RADIO_OFF);
    endtask : sleepRun
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        pinReq = 1'b0;
        countClear = 1'b0;
        ev = 10'h000;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rdChk("flags", ADDR_IRQ_FLAGS, 32'h10);
        rdChk("flags", ADDR_IRQ_FLAGS, 32'h00);
        rdChk("enable", ADDR_IRQ_ENABLE, 32'h00);
        rdChk("ctrl", ADDR_CTRL, 32'h12);
        rdChk("unmapped", 10'h040, 32'h00);
        ahb(1'b1, ADDR_IRQ_ENABLE, 32'hFF);
        for (int i = 0; i < 10; i++) begin
            pulse(i);
            irqChk(1'b1);
            rdChk("flag", ADDR_IRQ_FLAGS, i < 8 ? 32'h1 << i : (i == 8 ? 32'h10 : 32'h08));
            irqChk(1'b0);
        end
        pulse(0);
        pulse(1);
        rdChk("unlock", ADDR_IRQ_FLAGS, 32'h02);
        pulse(1);
        pulse(0);
        rdChk("lock", ADDR_IRQ_FLAGS, 32'h01);
        pulse(6);
        repeat (20) @(posedge clock);
        rdChk("held", ADDR_IRQ_FLAGS, 32'h40);
        ahb(1'b1, ADDR_IRQ_ENABLE, 32'h01);
        pulse(3);
        irqChk(1'b0);
        rdChk("polled", ADDR_IRQ_FLAGS, 32'h08);
        ahb(1'b1, ADDR_CTRL, 32'h10);
        pulse(3);
        rdChk("unpolled", ADDR_IRQ_FLAGS, 32'h00);
        pulse(0);
        irqChk(1'b1);
        ahb(1'b1, ADDR_CTRL, 32'h11);
        irqChk(1'b0);
        ahb(1'b0, ADDR_IRQ_FLAGS, 32'h00);
        irqChk(1'b1);
        ahb(1'b1, ADDR_CTRL, 32'h212);
        waitSt(ST_SYNTH_ON);
        pinReq <= 1'b1;
        waitSt(ST_BUSY_TX);
        chk("paEnable", 32'h1, {31'h00000000, paEnable});
        pulse(1);
        irqChk(1'b0);
        chk("paEnable", 32'h0, {31'h00000000, paEnable});
        pinReq <= 1'b0;
        ahb(1'b1, ADDR_CTRL, 32'h312);
        waitSt(ST_TX_RETRY);
        pinReq <= 1'b1;
        waitSt(ST_BUSY_TX_RETRY);
        pinReq <= 1'b0;
        repeat (10) @(posedge clock);
        chk("tx starts", 32'h2, txSeen);
        pulse(9);
        ahb(1'b1, ADDR_CTRL, 32'h412);
        waitSt(ST_RX_ACK);
        pulse(2);
        waitSt(ST_BUSY_RX_ACK);
        pinReq <= 1'b1;
        repeat (10) @(posedge clock);
        chk("ack starts", 32'h1, ackSeen);
        pinReq <= 1'b0;
        ahb(1'b1, ADDR_CTRL, 32'h112);
        waitSt(ST_RADIO_OFF);
        sleepRun(32'h012, ST_SLEEP, 10'h023);
        sleepRun(32'h032, ST_SLEEP, 10'h000);
        sleepRun(32'h042, ST_SLEEP, 10'h000);
        ahb(1'b1, ADDR_IRQ_ENABLE, 32'h5A);
        sleepRun(32'h522, ST_DEEP_SLEEP, 10'h023);
        rdChk("ctrl", ADDR_CTRL, 32'h12);
        rdChk("enable", ADDR_IRQ_ENABLE, 32'h00);
        rdChk("flags", ADDR_IRQ_FLAGS, 32'h10);
        rdChk("state", ADDR_STATE, {28'h0, ST_RADIO_OFF});
        tallyAndFinish();
    end
endmodule : test_sleep_wake_and_interrupt_logic
